// file: bench/bws_regs_assertions.sv
`timescale 1ns/10ps
module bws_regs_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sec_parity_err,
    input wire logic        sec_ca_sent,
    input wire logic        sec_ca_rcvd,
    input wire logic        sec_ur_rcvd,
    input wire logic        err_msg_sent,
    input wire logic        sec_poison_rcvd,
    input wire logic [31:0] io_addr,
    input wire logic [31:0] mem_addr,
    input wire logic        io_fwd,
    input wire logic        mem_fwd,
    input wire logic        irq
);
    logic [2:0] seen_q;
    logic       rd_setup;
    logic       mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = paddr inside {8'h1c, 8'h20, 8'h30, 8'h40, 8'h44, 8'h48};
    // abort flags have no software clear, so an or of events predicts them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_q <= 3'h0;
        else
            seen_q <= seen_q | {sec_ur_rcvd, sec_ca_rcvd, sec_ca_sent};
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence read_of(logic [7:0] a);
        rd_setup && paddr == a;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    slverr_set_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    io_nibble_a: assert property (read_of(8'h1c) |=>
        prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1) else $error("io nibble");
    sst_zero_a: assert property (read_of(8'h1c) |=>
        prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0)
        else $error("status zero bits set");
    mem_res_a: assert property (read_of(8'h20) |=>
        prdata[3:0] == 4'h0 && prdata[19:16] == 4'h0)
        else $error("memory reserved bits set");
    unmapped_zero_a: assert property (rd_setup && !mapped |=> prdata == '0)
        else $error("unmapped read not zero");
    abort_sticky_a: assert property (read_of(8'h1c) |=>
        prdata[29:27] == $past(seen_q)) else $error("abort flags wrong");
    reset_quiet_a: assert property (!$past(presetn) |-> !irq && !io_fwd)
        else $error("outputs not idle after reset");
    first_fwd_a: assert property (
        !$past(presetn) && io_addr[31:12] == '0 &&
        mem_addr[31:20] == '0 |=> io_fwd && mem_fwd)
        else $error("reset window not forwarded");
endmodule // bws_regs_checker

bind bws_regs bws_regs_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_parity_err(sec_parity_err), .sec_ca_sent(sec_ca_sent),
    .sec_ca_rcvd(sec_ca_rcvd), .sec_ur_rcvd(sec_ur_rcvd),
    .err_msg_sent(err_msg_sent), .sec_poison_rcvd(sec_poison_rcvd),
    .io_addr(io_addr), .mem_addr(mem_addr), .io_fwd(io_fwd),
    .mem_fwd(mem_fwd), .irq(irq));

// file: bench/bws_regs_tb_top.sv
`timescale 1ns/10ps
module bws_regs_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, io_addr, mem_addr, rd;
    logic [5:0]  ev;
    logic        io_fwd, mem_fwd, irq, err;
    int          mismatches, checked;
    logic [31:0] ioa [5] = '{32'h00011fff, 32'h00012000, 32'h00013fff,
                            32'h00014000, 32'h00002000};
    logic [31:0] ma [5] = '{32'h122fffff, 32'h12300000, 32'h124fffff,
                           32'h12500000, 32'h12400000};
    logic [1:0]  fe [5] = '{2'b00, 2'b11, 2'b11, 2'b00, 2'b01};
    logic [7:0]  offs [6] = '{8'h1c, 8'h20, 8'h30, 8'h40, 8'h44, 8'h48};

    bws_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sec_parity_err(ev[0]), .sec_ca_sent(ev[1]), .sec_ca_rcvd(ev[2]),
        .sec_ur_rcvd(ev[3]), .err_msg_sent(ev[4]), .sec_poison_rcvd(ev[5]),
        .io_addr(io_addr), .mem_addr(mem_addr), .io_fwd(io_fwd),
        .mem_fwd(mem_fwd), .irq(irq));

    always #25 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // called just after a rising edge; hit pulses events at the access edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [5:0] hit);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ev <= hit;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            final_report();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            ev <= 6'h00;
            @(posedge pclk);
        end
    endtask

    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge pclk);
        ev <= 6'h00;
        @(posedge pclk);
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge pclk);
    endtask

    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; ev = 0; io_addr = 0; mem_addr = 0;
        mismatches = 0;
        checked = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 6; i++)
        begin
            apb(0, offs[i], 0, 0);
            chk(rd, (i == 0) ? 32'h0000_0101 : 32'h0);
        end
        apb(1, 8'h24, 32'hffff_ffff, 0);
        chk({31'h0, err}, 32'h1);
        apb(0, 8'h24, 0, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, 8'h1c, 32'hffff_ffff, 0);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'h0000_f1f1);
        apb(1, 8'h20, 32'hffff_ffff, 0);
        apb(0, 8'h20, 0, 0);
        chk(rd, 32'hfff0_fff0);
        apb(1, 8'h1c, 32'h0000_3020, 0);
        apb(1, 8'h30, 32'h0001_0001, 0);
        apb(1, 8'h20, 32'h1240_1230, 0);
        apb(0, 8'h30, 0, 0);
        chk(rd, 32'h0001_0001);
        chk({31'h0, err}, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            io_addr <= ioa[i];
            mem_addr <= ma[i];
            @(posedge pclk);
            @(negedge pclk);
            chk({30'h0, io_fwd, mem_fwd}, {30'h0, fe[i]});
            @(posedge pclk);
        end
        pulse(6'h01);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'h0000_3121);
        apb(1, 8'h40, 32'h3, 0);
        apb(0, 8'h40, 0, 0);
        chk(rd, 32'h3);
        apb(1, 8'h44, 32'h3f, 0);
        apb(0, 8'h44, 0, 0);
        chk(rd, 32'h3f);
        pulse(6'h3f);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'hf900_3121);
        apb(0, 8'h48, 0, 0);
        chk(rd, 32'h3f);
        apb(1, 8'h1c, 32'hff00_3020, 0);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'h3800_3121);
        apb(1, 8'h1c, 32'h8000_3020, 6'h20);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'hb800_3121);
        apb(1, 8'h1c, 32'h0000_3020, 0);
        apb(1, 8'h40, 32'h0, 0);
        pulse(6'h11);
        apb(0, 8'h1c, 0, 0);
        chk(rd, 32'hb800_3121);
        chk_irq(1);
        apb(1, 8'h44, 32'h0, 0);
        chk_irq(0);
        apb(1, 8'h44, 32'h3f, 0);
        chk_irq(1);
        apb(1, 8'h48, 32'h3f, 0);
        chk_irq(0);
        apb(0, 8'h48, 0, 0);
        chk(rd, 32'h0);
        final_report();
    end
endmodule // bws_regs_tb_top

// file: design/bws_pkg.sv
package bws_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] OFF_IO_STATUS = 8'h1c;
    localparam logic [7:0] OFF_MEM_WIN   = 8'h20;
    localparam logic [7:0] OFF_IO_UPPER  = 8'h30;
    localparam logic [7:0] OFF_CTRL      = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h44;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h48;

    // io window byte pair inside the 1ch word
    localparam int unsigned IO_CAP_LO_LSB  = 0;
    localparam int unsigned IO_BASE_LSB    = 4;
    localparam int unsigned IO_CAP_HI_LSB  = 8;
    localparam int unsigned IO_LIMIT_LSB   = 12;
    localparam logic [3:0]  IO_ADDR32_CAP  = 4'h1;
    localparam logic [3:0]  IO_FIELD_RST   = 4'h0;
    localparam logic [11:0] IO_LOW_ZERO    = 12'h000;
    localparam logic [11:0] IO_LOW_ONES    = 12'hfff;

    // memory window word at 20h
    localparam int unsigned MEM_BASE_LSB   = 4;
    localparam int unsigned MEM_LIMIT_LSB  = 20;
    localparam logic [11:0] MEM_FIELD_RST  = 12'h000;
    localparam logic [19:0] MEM_LOW_ZERO   = 20'h00000;
    localparam logic [19:0] MEM_LOW_ONES   = 20'hfffff;

    // io upper halves at 30h
    localparam int unsigned IO_UP_BASE_LSB  = 0;
    localparam int unsigned IO_UP_LIMIT_LSB = 16;
    localparam logic [15:0] IO_UP_RST       = 16'h0000;

    // own control word
    localparam int unsigned CTRL_PERR_EN_BIT = 0;
    localparam int unsigned CTRL_SERR_EN_BIT = 1;

    // downstream status events, index into event vector
    localparam int unsigned NUM_EV   = 6;
    localparam int unsigned EV_PARITY  = 0;
    localparam int unsigned EV_CA_SENT = 1;
    localparam int unsigned EV_CA_RCVD = 2;
    localparam int unsigned EV_UR_RCVD = 3;
    localparam int unsigned EV_SERR    = 4;
    localparam int unsigned EV_POISON  = 5;

    // bit position of each event in the 1ch word
    localparam int unsigned SST_POS [NUM_EV] = '{24, 27, 28, 29, 30, 31};
    // events software may clear by writing one
    localparam logic [5:0] SST_W1C = 6'h31;
    localparam logic [5:0] EV_RST  = 6'h00;

endpackage

// file: design/bws_regs.sv
`timescale 1ns/10ps
module bws_regs
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sec_parity_err,
    input  wire logic        sec_ca_sent,
    input  wire logic        sec_ca_rcvd,
    input  wire logic        sec_ur_rcvd,
    input  wire logic        err_msg_sent,
    input  wire logic        sec_poison_rcvd,
    input  wire logic [31:0] io_addr,
    input  wire logic [31:0] mem_addr,
    output logic             io_fwd,
    output logic             mem_fwd,
    output logic             irq
);

    logic [3:0]  io_base_q;
    logic [3:0]  io_limit_q;
    logic [11:0] mem_base_q;
    logic [11:0] mem_limit_q;
    logic [15:0] io_up_base_q;
    logic [15:0] io_up_limit_q;
    logic        perr_en_q;
    logic        serr_en_q;
    logic [5:0]  irq_mask_q;
    logic [5:0]  sst_q;
    logic [5:0]  irq_stat_q;
    logic [5:0]  ev;
    logic [31:0] prdata_q;
    logic        io_fwd_q;
    logic        mem_fwd_q;
    logic        irq_q;
    logic [31:0] io_bottom;
    logic [31:0] io_top;
    logic [31:0] mem_bottom;
    logic [31:0] mem_top;
    logic        io_hit;
    logic        mem_hit;
    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        wr_io_st;
    logic        wr_mem;
    logic        wr_io_up;
    logic        wr_ctrl;
    logic        wr_mask;
    logic        wr_istat;
    logic [31:0] rd_word;
    logic [31:0] sst_word;

    // apb decode; zero wait states, so every access phase ends at once
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr     = access && pwrite;

    always_comb
    begin
        case (paddr)
            bws_pkg::OFF_IO_STATUS,
            bws_pkg::OFF_MEM_WIN,
            bws_pkg::OFF_IO_UPPER,
            bws_pkg::OFF_CTRL,
            bws_pkg::OFF_IRQ_MASK,
            bws_pkg::OFF_IRQ_STAT: mapped = 1'b1;
            default:               mapped = 1'b0;
        endcase
    end

    assign wr_io_st = wr && (paddr == bws_pkg::OFF_IO_STATUS);
    assign wr_mem   = wr && (paddr == bws_pkg::OFF_MEM_WIN);
    assign wr_io_up = wr && (paddr == bws_pkg::OFF_IO_UPPER);
    assign wr_ctrl  = wr && (paddr == bws_pkg::OFF_CTRL);
    assign wr_mask  = wr && (paddr == bws_pkg::OFF_IRQ_MASK);
    assign wr_istat = wr && (paddr == bws_pkg::OFF_IRQ_STAT);

    assign pready  = 1'b1;
    // unmapped offsets answer with an error and change nothing
    assign pslverr = access && !mapped;

    // io window fields; capability nibbles are not stored at all
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_base_q  <= bws_pkg::IO_FIELD_RST;
            io_limit_q <= bws_pkg::IO_FIELD_RST;
        end
        else if (wr_io_st)
        begin
            io_base_q  <= pwdata[bws_pkg::IO_BASE_LSB +: 4];
            io_limit_q <= pwdata[bws_pkg::IO_LIMIT_LSB +: 4];
        end
    end

    // memory window word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_base_q  <= bws_pkg::MEM_FIELD_RST;
            mem_limit_q <= bws_pkg::MEM_FIELD_RST;
        end
        else if (wr_mem)
        begin
            mem_base_q  <= pwdata[bws_pkg::MEM_BASE_LSB +: 12];
            mem_limit_q <= pwdata[bws_pkg::MEM_LIMIT_LSB +: 12];
        end
    end

    // upper halves of the io window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_up_base_q  <= bws_pkg::IO_UP_RST;
            io_up_limit_q <= bws_pkg::IO_UP_RST;
        end
        else if (wr_io_up)
        begin
            io_up_base_q  <= pwdata[bws_pkg::IO_UP_BASE_LSB +: 16];
            io_up_limit_q <= pwdata[bws_pkg::IO_UP_LIMIT_LSB +: 16];
        end
    end

    // enables that gate two of the status events
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            perr_en_q <= 1'b0;
            serr_en_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            perr_en_q <= pwdata[bws_pkg::CTRL_PERR_EN_BIT];
            serr_en_q <= pwdata[bws_pkg::CTRL_SERR_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_q <= bws_pkg::EV_RST;
        end
        else if (wr_mask)
        begin
            irq_mask_q <= pwdata[5:0];
        end
    end

    // event vector; parity and error message need their enables
    always_comb
    begin
        ev = bws_pkg::EV_RST;
        ev[bws_pkg::EV_PARITY]  = sec_parity_err && perr_en_q;
        ev[bws_pkg::EV_CA_SENT] = sec_ca_sent;
        ev[bws_pkg::EV_CA_RCVD] = sec_ca_rcvd;
        ev[bws_pkg::EV_UR_RCVD] = sec_ur_rcvd;
        ev[bws_pkg::EV_SERR]    = err_msg_sent && serr_en_q;
        ev[bws_pkg::EV_POISON]  = sec_poison_rcvd;
    end

    // status bits 27..29 cannot be cleared by software, only by reset
    for (genvar i = 0; i < bws_pkg::NUM_EV; i++)
    begin : g_ev
        bws_sticky_bit u_sst
        (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (ev[i]),
            .clr     (wr_io_st && bws_pkg::SST_W1C[i] &&
                      pwdata[bws_pkg::SST_POS[i]]),
            .flag_q  (sst_q[i])
        );

        bws_sticky_bit u_irq
        (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (ev[i]),
            .clr     (wr_istat && pwdata[i]),
            .flag_q  (irq_stat_q[i])
        );
    end

    // 1ch word; reserved bits stay zero, hardwired capability nibbles read 1
    always_comb
    begin
        sst_word = 32'h0000_0000;
        sst_word[bws_pkg::IO_CAP_LO_LSB +: 4] = bws_pkg::IO_ADDR32_CAP;
        sst_word[bws_pkg::IO_BASE_LSB +: 4]   = io_base_q;
        sst_word[bws_pkg::IO_CAP_HI_LSB +: 4] = bws_pkg::IO_ADDR32_CAP;
        sst_word[bws_pkg::IO_LIMIT_LSB +: 4]  = io_limit_q;
        for (int k = 0; k < bws_pkg::NUM_EV; k++)
        begin
            sst_word[bws_pkg::SST_POS[k]] = sst_q[k];
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            bws_pkg::OFF_IO_STATUS:
            begin
                rd_word = sst_word;
            end
            bws_pkg::OFF_MEM_WIN:
            begin
                rd_word[bws_pkg::MEM_BASE_LSB +: 12]  = mem_base_q;
                rd_word[bws_pkg::MEM_LIMIT_LSB +: 12] = mem_limit_q;
            end
            bws_pkg::OFF_IO_UPPER:
            begin
                rd_word[bws_pkg::IO_UP_BASE_LSB +: 16]  = io_up_base_q;
                rd_word[bws_pkg::IO_UP_LIMIT_LSB +: 16] = io_up_limit_q;
            end
            bws_pkg::OFF_CTRL:
            begin
                rd_word[bws_pkg::CTRL_PERR_EN_BIT] = perr_en_q;
                rd_word[bws_pkg::CTRL_SERR_EN_BIT] = serr_en_q;
            end
            bws_pkg::OFF_IRQ_MASK:
            begin
                rd_word[5:0] = irq_mask_q;
            end
            bws_pkg::OFF_IRQ_STAT:
            begin
                rd_word[5:0] = irq_stat_q;
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // read data captured in setup so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (setup && !pwrite)
        begin
            prdata_q <= rd_word;
        end
    end

    assign prdata = prdata_q;

    // window bounds with their implied low address bits
    assign io_bottom  = {io_up_base_q, io_base_q,
                         bws_pkg::IO_LOW_ZERO};
    assign io_top     = {io_up_limit_q, io_limit_q,
                         bws_pkg::IO_LOW_ONES};
    assign mem_bottom = {mem_base_q, bws_pkg::MEM_LOW_ZERO};
    assign mem_top    = {mem_limit_q, bws_pkg::MEM_LOW_ONES};

    bws_window_hit
    #(
        .W (32)
    )
    u_io_hit
    (
        .addr   (io_addr),
        .bottom (io_bottom),
        .top    (io_top),
        .hit    (io_hit)
    );

    bws_window_hit
    #(
        .W (32)
    )
    u_mem_hit
    (
        .addr   (mem_addr),
        .bottom (mem_bottom),
        .top    (mem_top),
        .hit    (mem_hit)
    );

    // one cycle of latency keeps the wide compare off the output path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_fwd_q  <= 1'b0;
            mem_fwd_q <= 1'b0;
        end
        else
        begin
            io_fwd_q  <= io_hit;
            mem_fwd_q <= mem_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign io_fwd  = io_fwd_q;
    assign mem_fwd = mem_fwd_q;
    assign irq     = irq_q;

endmodule // bws_regs

// file: design/bws_sticky_bit.sv
`timescale 1ns/10ps
// sticky flag; a set in the clearing cycle wins
module bws_sticky_bit
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag_q
);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (set)
        begin
            flag_q <= 1'b1;
        end
        else if (clr)
        begin
            flag_q <= 1'b0;
        end
    end

endmodule // bws_sticky_bit

// file: design/bws_window_hit.sv
`timescale 1ns/10ps
// inclusive range compare, bottom and top both count as inside
module bws_window_hit
#(
    parameter int unsigned W = 32
)
(
    input  wire logic [W-1:0] addr,
    input  wire logic [W-1:0] bottom,
    input  wire logic [W-1:0] top,
    output logic              hit
);

    assign hit = (addr >= bottom) && (addr <= top);

endmodule // bws_window_hit
